// ---- hw/scld_config_latch.v ----
`timescale 1ns/1ps
`include "scld_consts.vh"

// Operation
// [RULE_01] Training multiplier select: 0 direct, 1 doubled
// [RULE_02] Host avoids multiplier 1 at low speed
// [RULE_03] Receive power enable resets 0, gates analog
// [RULE_04] Receive mode resets 11; 01 video, 10 BIST
// [RULE_05] Host never leaves receive mode 00/11
// [RULE_06] Reclocker driver enables reset 0, power gate
// [RULE_07] Both reclocker drivers off powers reclocker down
// [RULE_08] Device reset disables every serial driver
// [RULE_09] Clock source resets 1: reference, buffer bypassed
// [RULE_10] Rate select: 0 times ten, 1 times twenty
// [RULE_11] Reference clock plus rate 1: both edges
// [RULE_12] Host avoids rate 1 at low speed
// [RULE_13] Transmit BIST disable resets 1; 0 enables
// [RULE_14] Transmit driver enables reset 0, power gate
// [RULE_15] Both transmit drivers off powers channel down
// [RULE_16] Buffer reset latch resets 1; 0 recenters
// [RULE_17] Buffer reset synchronised to transmit input clock
// [RULE_18] Buffer reset latch clears itself after use
// [RULE_19] Write strobe low loads data into bank
// [RULE_20] Host never writes banks three or four
// [RULE_21] Host configures static, dynamic, then buffer reset
// [RULE_22] Latches hold until rewritten or reset

module scld_config_latch (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Configuration write port
    input wire cfg_write_strobe_n,
    input wire [2:0] cfg_addr,
    input wire [6:0] cfg_data,
    // Speed straps
    input wire rx_speed_select,
    input wire tx_speed_select,
    // Transmit input clock, sampled as a level
    input wire tx_input_clock,
    // Receive side decode
    output reg train_clk_mult_sel,
    output reg train_clk_doubled,
    output reg rx_channel_power_enable,
    output reg [1:0] rx_receive_mode_sel,
    output reg rx_bist_enable,
    output reg rx_video_enable,
    output reg rx_mode_invalid,
    output reg reclk_primary_drv_en,
    output reg reclk_secondary_drv_en,
    output reg reclk_logic_power_enable,
    output reg rx_rate_invalid,
    // Transmit side decode
    output reg tx_input_clock_sel,
    output reg tx_pab_bypass,
    output reg tx_pll_rate_sel,
    output reg tx_clock_out_double,
    output reg tx_capture_both_edges,
    output reg tx_rate_invalid,
    output reg tx_selftest_disable,
    output reg tx_primary_drv_en,
    output reg tx_secondary_drv_en,
    output reg tx_logic_power_enable,
    output reg phase_align_buf_recenter,
    output reg pab_recenter_pulse
);

    reg tx_clk_prev_q;
    reg pab_sync_prev_q;
    wire tx_clk_rise;
    wire pab_sync;
    wire wr_en;
    wire wr_rx_static1;
    wire wr_rx_dyn;
    wire wr_tx_static1;
    wire wr_tx_dyn;
    wire pab_write_req;

    assign wr_en = ~cfg_write_strobe_n;
    assign tx_clk_rise = tx_input_clock & ~tx_clk_prev_q;
    // Banks 0, 5 and test banks 3, 4 decode to nothing
    assign wr_rx_static1 = wr_en && (cfg_addr == `SCLD_ADDR_RX_STATIC1);
    assign wr_rx_dyn = wr_en && (cfg_addr == `SCLD_ADDR_RX_DYN);
    assign wr_tx_static1 = wr_en && (cfg_addr == `SCLD_ADDR_TX_STATIC1);
    assign wr_tx_dyn = wr_en && (cfg_addr == `SCLD_ADDR_TX_DYN);
    assign pab_write_req = wr_tx_dyn && !cfg_data[`SCLD_BIT_PAB];

    // [RULE_17] Sample on transmit clock rise
    scld_sync u_pab_sync (
        .clk(clk),
        .rst_n(rst_n),
        .smp_en(tx_clk_rise),
        .d_in(phase_align_buf_recenter),
        .q_out(pab_sync)
    );

    // Edge detector for the level-sampled transmit input clock
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_clk_prev_q <= 1'b0;
        end else begin
            tx_clk_prev_q <= tx_input_clock;
        end
    end

    // [RULE_19] Receive banks load on strobe
    // [RULE_22] Otherwise hold value
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // [RULE_08] Reclocker drivers off in reset
            train_clk_mult_sel <= `SCLD_RST_TRAIN_MULT;
            rx_channel_power_enable <= `SCLD_RST_RX_PWR;
            rx_receive_mode_sel <= `SCLD_RST_RX_MODE;
            reclk_primary_drv_en <= `SCLD_RST_DRV_EN;
            reclk_secondary_drv_en <= `SCLD_RST_DRV_EN;
        end else begin
            if (wr_rx_static1) begin
                train_clk_mult_sel <= cfg_data[`SCLD_BIT_TRAIN_MULT];
            end
            if (wr_rx_dyn) begin
                rx_receive_mode_sel <= {cfg_data[`SCLD_BIT_RX_MODE_HI],
                                        cfg_data[`SCLD_BIT_RX_MODE_LO]};
                rx_channel_power_enable <= cfg_data[`SCLD_BIT_RX_PWR];
                reclk_secondary_drv_en <= cfg_data[`SCLD_BIT_RECLK_SEC];
                reclk_primary_drv_en <= cfg_data[`SCLD_BIT_RECLK_PRI];
            end
        end
    end

    // [RULE_19] Transmit banks load on strobe
    // [RULE_22] Otherwise hold value
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // [RULE_08] Transmit drivers off in reset
            tx_input_clock_sel <= `SCLD_RST_TX_CKSEL;
            tx_pll_rate_sel <= `SCLD_RST_TX_RATE;
            // [RULE_13] Transmit BIST starts disabled
            tx_selftest_disable <= `SCLD_RST_TX_BIST_DIS;
            tx_primary_drv_en <= `SCLD_RST_DRV_EN;
            tx_secondary_drv_en <= `SCLD_RST_DRV_EN;
        end else begin
            if (wr_tx_static1) begin
                tx_input_clock_sel <= cfg_data[`SCLD_BIT_TX_CKSEL];
                tx_pll_rate_sel <= cfg_data[`SCLD_BIT_TX_RATE];
            end
            if (wr_tx_dyn) begin
                // [RULE_13] Zero enables transmit BIST
                tx_selftest_disable <= cfg_data[`SCLD_BIT_TX_BIST_DIS];
                tx_secondary_drv_en <= cfg_data[`SCLD_BIT_TX_SEC];
                tx_primary_drv_en <= cfg_data[`SCLD_BIT_TX_PRI];
            end
        end
    end

    // [RULE_16] Write 0 starts recenter, write 1 does nothing
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_align_buf_recenter <= `SCLD_RST_PAB;
            pab_sync_prev_q <= 1'b1;
            pab_recenter_pulse <= 1'b0;
        end else begin
            if (tx_clk_rise) begin
                pab_sync_prev_q <= pab_sync;
            end
            // Recenter fires once per falling synced level
            pab_recenter_pulse <= tx_clk_rise & pab_sync_prev_q & ~pab_sync;
            // [RULE_18] Self clear once first stage took the low
            // Early clear: a new write can meet a stale synced low and merge with it
            // A write wins a tie with the clear
            if (pab_write_req) begin
                phase_align_buf_recenter <= 1'b0;
            end else if (tx_clk_rise) begin
                phase_align_buf_recenter <= 1'b1;
            end
        end
    end

    // Receive derived controls, registered so every output is a flop
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            train_clk_doubled <= 1'b0;
            rx_bist_enable <= 1'b0;
            rx_video_enable <= 1'b0;
            rx_mode_invalid <= 1'b1;
            reclk_logic_power_enable <= 1'b0;
            rx_rate_invalid <= 1'b0;
        end else begin
            // [RULE_01] Training clock doubling
            train_clk_doubled <= train_clk_mult_sel;
            // [RULE_02] Flag reserved speed combination
            rx_rate_invalid <= train_clk_mult_sel & ~rx_speed_select;
            // [RULE_04] Mode decode; [RULE_03] needs power
            rx_bist_enable <= rx_channel_power_enable &
                              (rx_receive_mode_sel == `SCLD_RX_MODE_BIST);
            rx_video_enable <= rx_channel_power_enable &
                               (rx_receive_mode_sel == `SCLD_RX_MODE_VIDEO);
            // [RULE_05] Codes 00 and 11 reported
            rx_mode_invalid <= (rx_receive_mode_sel != `SCLD_RX_MODE_VIDEO) &&
                               (rx_receive_mode_sel != `SCLD_RX_MODE_BIST);
            // [RULE_07] Reclocker off with both drivers
            // [RULE_06] Driver enables gate power
            reclk_logic_power_enable <= reclk_primary_drv_en | reclk_secondary_drv_en;
        end
    end

    // Transmit derived controls
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_pab_bypass <= 1'b1;
            tx_clock_out_double <= 1'b0;
            tx_capture_both_edges <= 1'b0;
            tx_rate_invalid <= 1'b0;
            tx_logic_power_enable <= 1'b0;
        end else begin
            // [RULE_09] Reference clock bypasses buffer
            tx_pab_bypass <= tx_input_clock_sel;
            // [RULE_10] Twenty times when rate 1
            tx_clock_out_double <= tx_pll_rate_sel;
            // [RULE_11] Dual edge capture
            tx_capture_both_edges <= tx_input_clock_sel & tx_pll_rate_sel;
            // [RULE_12] Flag reserved speed combination
            tx_rate_invalid <= tx_pll_rate_sel & ~tx_speed_select;
            // [RULE_15] Channel off with both drivers
            // [RULE_14] Driver enables gate power
            tx_logic_power_enable <= tx_primary_drv_en | tx_secondary_drv_en;
        end
    end

endmodule

// ---- hw/scld_consts.vh ----
`ifndef SCLD_CONSTS_VH
`define SCLD_CONSTS_VH

// Latch bank addresses
`define SCLD_ADDR_RX_STATIC0 3'h0
`define SCLD_ADDR_RX_STATIC1 3'h1
`define SCLD_ADDR_RX_DYN 3'h2
`define SCLD_ADDR_TEST0 3'h3
`define SCLD_ADDR_TEST1 3'h4
`define SCLD_ADDR_TX_STATIC0 3'h5
`define SCLD_ADDR_TX_STATIC1 3'h6
`define SCLD_ADDR_TX_DYN 3'h7

// Field positions
`define SCLD_BIT_TRAIN_MULT 0
`define SCLD_BIT_RX_MODE_HI 6
`define SCLD_BIT_RX_PWR 5
`define SCLD_BIT_RX_MODE_LO 4
`define SCLD_BIT_RECLK_SEC 2
`define SCLD_BIT_RECLK_PRI 1
`define SCLD_BIT_TX_CKSEL 1
`define SCLD_BIT_TX_RATE 0
`define SCLD_BIT_TX_BIST_DIS 3
`define SCLD_BIT_TX_SEC 2
`define SCLD_BIT_TX_PRI 1
`define SCLD_BIT_PAB 0

// Reset values
`define SCLD_RST_TRAIN_MULT 1'b0
`define SCLD_RST_RX_PWR 1'b0
`define SCLD_RST_RX_MODE 2'h3
`define SCLD_RST_DRV_EN 1'b0
`define SCLD_RST_TX_CKSEL 1'b1
`define SCLD_RST_TX_RATE 1'b0
`define SCLD_RST_TX_BIST_DIS 1'b1
`define SCLD_RST_PAB 1'b1

// Receive mode codes
`define SCLD_RX_MODE_VIDEO 2'h1
`define SCLD_RX_MODE_BIST 2'h2

// Synchroniser depth in the transmit input clock domain
`define SCLD_SYNC_STAGES 2

`endif

// ---- hw/scld_sync.v ----
`timescale 1ns/1ps
`include "scld_consts.vh"

module scld_sync (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Sampling enable (one rising edge of the sampled clock)
    input wire smp_en,
    // Level in and out
    input wire d_in,
    output wire q_out
);

    reg [`SCLD_SYNC_STAGES-1:0] stage_q;

    // First stage feeds only the second; resets to idle high
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_q <= {`SCLD_SYNC_STAGES{1'b1}};
        end else if (smp_en) begin
            stage_q <= {stage_q[`SCLD_SYNC_STAGES-2:0], d_in};
        end
    end

    assign q_out = stage_q[`SCLD_SYNC_STAGES-1];

endmodule

// ---- test/scld_host.sv ----
`timescale 1ns/1ps
module scld_host (
    // Clock
    input wire clk,
    // Configuration write port
    output logic cfg_write_strobe_n,
    output logic [2:0] cfg_addr,
    output logic [6:0] cfg_data
);
    initial begin
        cfg_write_strobe_n = 1'b1;
        cfg_addr = 3'h0;
        cfg_data = 7'h00;
    end
    task automatic wr(input logic [2:0] a, input logic [6:0] d);
        @(negedge clk);
        cfg_write_strobe_n = 1'b0;
        cfg_addr = a;
        cfg_data = d;
        @(negedge clk);
        cfg_write_strobe_n = 1'b1;
        // Released bus must not look like the last value
        cfg_addr = ~a;
        cfg_data = ~d;
    endtask
endmodule

// ---- test/scld_monitor.sv ----
`timescale 1ns/1ps
module scld_monitor (
    // Clock, reset and write port
    input wire clk,
    input wire rst_n,
    input wire cfg_write_strobe_n,
    input wire [2:0] cfg_addr,
    input wire [6:0] cfg_data,
    // Decoded outputs
    input wire [1:0] rx_receive_mode_sel,
    input wire reclk_primary_drv_en,
    input wire reclk_secondary_drv_en,
    input wire reclk_logic_power_enable,
    input wire tx_input_clock_sel,
    input wire tx_pll_rate_sel,
    input wire tx_capture_both_edges,
    input wire tx_primary_drv_en,
    input wire tx_secondary_drv_en,
    input wire tx_logic_power_enable,
    input wire phase_align_buf_recenter,
    input wire pab_recenter_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire wr = !cfg_write_strobe_n;
    sequence wr_tx_dyn; wr && cfg_addr == 3'h7; endsequence
    sequence pab_req; wr_tx_dyn ##0 !cfg_data[0]; endsequence
    a_tx_drv_load: assert property (wr_tx_dyn |=>
        tx_primary_drv_en == $past(cfg_data[1])
        && tx_secondary_drv_en == $past(cfg_data[2])) else $error("tx enable not loaded");
    a_rx_mode_load: assert property (wr && cfg_addr == 3'h2 |=>
        rx_receive_mode_sel == {$past(cfg_data[6]), $past(cfg_data[4])}) else $error("rx mode");
    a_latch_hold: assert property (!wr || cfg_addr inside {3'h0, 3'h3, 3'h4, 3'h5} |=>
        $stable({rx_receive_mode_sel, tx_input_clock_sel, tx_pll_rate_sel, tx_primary_drv_en}))
        else $error("latch changed without write");
    a_reclk_power: assert property (reclk_logic_power_enable ==
        $past(reclk_primary_drv_en | reclk_secondary_drv_en)) else $error("reclk power");
    a_tx_power: assert property (tx_logic_power_enable ==
        $past(tx_primary_drv_en | tx_secondary_drv_en)) else $error("tx power");
    a_both_edges: assert property (tx_capture_both_edges ==
        $past(tx_input_clock_sel & tx_pll_rate_sel)) else $error("capture edges");
    a_reset_drv_off: assert property (disable iff (1'b0) !rst_n |-> !(tx_primary_drv_en
        | tx_secondary_drv_en | reclk_primary_drv_en | reclk_secondary_drv_en))
        else $error("driver on in reset");
    a_pab_set: assert property (pab_req |=> !phase_align_buf_recenter)
        else $error("recenter not latched");
    a_pab_sync: assert property ($fell(phase_align_buf_recenter) |->
        ##[2:40] pab_recenter_pulse) else $error("recenter pulse missing");
    a_pab_clear: assert property (pab_recenter_pulse |->
        ##[0:2] phase_align_buf_recenter) else $error("recenter not cleared");
endmodule
bind scld_config_latch scld_monitor u_mon (.clk, .rst_n, .cfg_write_strobe_n, .cfg_addr,
    .cfg_data, .rx_receive_mode_sel, .reclk_primary_drv_en, .reclk_secondary_drv_en,
    .reclk_logic_power_enable, .tx_input_clock_sel, .tx_pll_rate_sel, .tx_capture_both_edges,
    .tx_primary_drv_en, .tx_secondary_drv_en, .tx_logic_power_enable,
    .phase_align_buf_recenter, .pab_recenter_pulse);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected %0t: compare %0d", $time, checks); end end
module testbench;
    logic clk, rst_n, rx_speed_select, tx_speed_select, tx_input_clock;
    wire cfg_write_strobe_n;
    wire [2:0] cfg_addr;
    wire [6:0] cfg_data;
    wire [1:0] rx_receive_mode_sel;
    wire train_clk_mult_sel, train_clk_doubled, rx_channel_power_enable, rx_bist_enable;
    wire rx_video_enable, rx_mode_invalid, reclk_primary_drv_en, reclk_secondary_drv_en;
    wire reclk_logic_power_enable, rx_rate_invalid, tx_input_clock_sel, tx_pab_bypass;
    wire tx_pll_rate_sel, tx_clock_out_double, tx_capture_both_edges, tx_rate_invalid;
    wire tx_selftest_disable, tx_primary_drv_en, tx_secondary_drv_en, tx_logic_power_enable;
    wire phase_align_buf_recenter, pab_recenter_pulse;
    int n_errors, checks, seed, tick, a, d, b1, b2, b6, b7;
    int am[6] = '{0, 1, 2, 5, 6, 7};
    scld_host host (.clk, .cfg_write_strobe_n, .cfg_addr, .cfg_data);
    scld_config_latch dut (.clk, .rst_n, .cfg_write_strobe_n, .cfg_addr, .cfg_data,
        .rx_speed_select, .tx_speed_select, .tx_input_clock, .train_clk_mult_sel,
        .train_clk_doubled, .rx_channel_power_enable, .rx_receive_mode_sel, .rx_bist_enable,
        .rx_video_enable, .rx_mode_invalid, .reclk_primary_drv_en, .reclk_secondary_drv_en,
        .reclk_logic_power_enable, .rx_rate_invalid, .tx_input_clock_sel, .tx_pab_bypass,
        .tx_pll_rate_sel, .tx_clock_out_double, .tx_capture_both_edges, .tx_rate_invalid,
        .tx_selftest_disable, .tx_primary_drv_en, .tx_secondary_drv_en,
        .tx_logic_power_enable, .phase_align_buf_recenter, .pab_recenter_pulse);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Slow enough for the clk-sampled edge detector
    initial forever begin
        repeat (2) @(negedge clk);
        tx_input_clock = ~tx_input_clock;
    end
    task automatic check_all();
        `CHK({train_clk_mult_sel, train_clk_doubled}, {b1[0], b1[0]})
        `CHK(rx_rate_invalid, b1[0] & ~rx_speed_select)
        `CHK(rx_channel_power_enable, b2[5])
        `CHK({rx_receive_mode_sel, rx_mode_invalid}, {b2[6], b2[4], b2[6] == b2[4]})
        `CHK(rx_bist_enable, b2[5] & b2[6] & ~b2[4])
        `CHK(rx_video_enable, b2[5] & b2[4] & ~b2[6])
        `CHK({reclk_primary_drv_en, reclk_secondary_drv_en}, {b2[1], b2[2]})
        `CHK(reclk_logic_power_enable, b2[1] | b2[2])
        `CHK({tx_input_clock_sel, tx_pab_bypass}, {b6[1], b6[1]})
        `CHK({tx_pll_rate_sel, tx_clock_out_double}, {b6[0], b6[0]})
        `CHK(tx_capture_both_edges, b6[1] & b6[0])
        `CHK(tx_rate_invalid, b6[0] & ~tx_speed_select)
        `CHK(tx_selftest_disable, b7[3])
        `CHK({tx_primary_drv_en, tx_secondary_drv_en}, {b7[1], b7[2]})
        `CHK(tx_logic_power_enable, b7[1] | b7[2])
        `CHK({phase_align_buf_recenter, pab_recenter_pulse}, 2'b10)
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        b1 = 0;
        b2 = 'h50;
        b6 = 'h02;
        b7 = 'h09;
        repeat (4) @(negedge clk);
        check_all();
        rst_n = 1'b1;
    endtask
    task automatic final_report();
        if (n_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        seed = 15;
        {rx_speed_select, tx_speed_select, tx_input_clock} = 3'h6;
        do_reset();
        repeat (80) begin
            a = am[$unsigned($random(seed)) % 6];
            d = $random(seed);
            rx_speed_select = $random(seed);
            tx_speed_select = $random(seed);
            if (a == 2) d = (d & 'h2F) | (d[0] ? 'h40 : 'h10);
            if (a == 1 && !rx_speed_select) d[0] = 0;
            if (a == 6 && !tx_speed_select) d[0] = 0;
            if (a == 7) d[0] = 1;
            // other banks leave the model alone
            case (a)
                1: b1 = d;
                2: b2 = d;
                6: b6 = d;
                7: b7 = d;
                default: ;
            endcase
            host.wr(a[2:0], d[6:0]);
            repeat (2) @(negedge clk);
            check_all();
        end
        b6 = 'h00;
        host.wr(3'h6, 7'h00);
        b7 = 'h07;
        host.wr(3'h7, 7'h07);
        host.wr(3'h7, 7'h06);
        `CHK(phase_align_buf_recenter, 1'b0)
        tick = 0;
        while (pab_recenter_pulse !== 1'b1 && tick < 40) begin
            @(negedge clk);
            tick++;
        end
        `CHK(pab_recenter_pulse, 1'b1)
        repeat (3) @(negedge clk);
        check_all();
        do_reset();
        final_report();
    end
    initial begin
        #20000;
        n_errors++;
        final_report();
    end
endmodule
